// ===== sbf_pkg.sv
// shared constants and types for the system burst line fill block
`default_nettype none
package sbf_pkg;
	// ========================================
	// widths and line geometry
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 64;
	localparam int IDX_W       = 3;
	localparam int DW_LSB      = 3;
	localparam int BEATS_32B   = 4;
	localparam int BEATS_64B   = 8;
	// ========================================
	// lookup count in clocks and wait counter width in bits
	localparam int LOOKUP_CLKS = 2;
	localparam int WAIT_W      = 4;
	// ========================================
	// access kinds seen on the processor side
	typedef enum logic [1:0] {
		SBF_KIND_READ  = 2'b00, // primary cache read miss
		SBF_KIND_RWITM = 2'b01, // touch load or write miss
		SBF_KIND_OTHER = 2'b10  // table search, allocate load, exchange
	} sbf_kind_e;
	typedef enum logic [2:0] {
		SBF_D_IDLE   = 3'b000,
		SBF_D_LOOKUP = 3'b001,
		SBF_D_HIT    = 3'b010,
		SBF_D_REQ    = 3'b011,
		SBF_D_ADDR   = 3'b100,
		SBF_D_DATA   = 3'b101
	} sbf_dev_e;
	typedef enum logic [1:0] {
		SBF_H_IDLE = 2'b00,
		SBF_H_WAIT = 2'b01,
		SBF_H_BEAT = 2'b10,
		SBF_H_TAIL = 2'b11
	} sbf_host_e;
endpackage : sbf_pkg
`default_nettype wire

// ===== sbf_bus_if.sv
// system bus between the cache controller end and the arbiter/memory end
`default_nettype none
interface sbf_bus_if;
	import sbf_pkg::*;
	logic              sys_bus_request;
	logic              sys_bus_grant;
	logic              sys_address_busy;
	logic              sys_transfer_start;
	logic              sys_burst_flag;
	logic              sys_memory_coherent;
	logic              sys_invalidate_hint;
	logic [ADDR_W-1:0] sys_addr;
	logic              sys_addr_oe;
	logic              sys_address_ack;
	logic              sys_data_grant;
	logic              sys_data_busy;
	logic              sys_transfer_ack;
	logic [DATA_W-1:0] sys_data;
	modport dev_mp (
		output sys_bus_request, sys_address_busy, sys_transfer_start, sys_burst_flag,
		output sys_memory_coherent, sys_invalidate_hint, sys_addr, sys_addr_oe,
		output sys_data_busy,
		input  sys_bus_grant, sys_address_ack, sys_data_grant, sys_transfer_ack, sys_data
	);
	modport sys_mp (
		input  sys_bus_request, sys_address_busy, sys_transfer_start, sys_burst_flag,
		input  sys_memory_coherent, sys_invalidate_hint, sys_addr, sys_addr_oe,
		input  sys_data_busy,
		output sys_bus_grant, sys_address_ack, sys_data_grant, sys_transfer_ack, sys_data
	);
endinterface : sbf_bus_if
`default_nettype wire

// ===== sbf_beat_seq.sv
// beat counter and beat index order for one line transfer
`default_nettype none
module sbf_beat_seq
	import sbf_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             start_in,
	input  wire logic [IDX_W-1:0] crit_in,
	input  wire logic             line64_in,
	input  wire logic             cwf_in,
	input  wire logic             single_in,
	input  wire logic             step_in,
	output logic      [IDX_W-1:0] idx_out,
	output logic                  last_out
);
	logic [IDX_W-1:0] cnt_r, cnt_nxt, crit_r, crit_nxt, mask_r, mask_nxt;
	logic             cwf_r, cwf_nxt;

	// ========================================
	// next count; start wins over step
	always_comb
	begin
		cnt_nxt  = cnt_r;
		crit_nxt = crit_r;
		mask_nxt = mask_r;
		cwf_nxt  = cwf_r;
		if (start_in)
		begin
			cnt_nxt  = '0;
			crit_nxt = crit_in;
			cwf_nxt  = cwf_in;
			mask_nxt = single_in ? 3'h0 : (line64_in ? IDX_W'(BEATS_64B - 1)
				: IDX_W'(BEATS_32B - 1));
		end
		else if (step_in)
			cnt_nxt = cnt_r + 3'h1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_r  <= '0;
			crit_r <= '0;
			mask_r <= '0;
			cwf_r  <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			crit_r <= crit_nxt;
			mask_r <= mask_nxt;
			cwf_r  <= cwf_nxt;
		end
	end

	// wrap from the critical word, or count up from word zero
	assign idx_out  = cwf_r ? ((crit_r + cnt_r) & mask_r) : (cnt_r & mask_r);
	assign last_out = (cnt_r == mask_r);
endmodule : sbf_beat_seq
`default_nettype wire

// ===== sbf_dev_end.sv
// cache controller end: processor side miss handling and system burst read
`default_nettype none
module sbf_dev_end
	import sbf_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	sbf_bus_if.dev_mp              bus,
	input  wire logic              half_speed_in,
	input  wire logic              line64_in,
	input  wire logic              cwf_in,
	input  wire logic              proc_transfer_start_in,
	input  wire logic [ADDR_W-1:0] proc_addr_in,
	input  wire logic              proc_burst_flag_in,
	input  wire logic              proc_cache_inhibit_in,
	input  wire sbf_kind_e         proc_kind_in,
	input  wire logic              l2_hit_in,
	input  wire logic [DATA_W-1:0] ram_rdata_in,
	output logic                   proc_transfer_ack_out,
	output logic      [DATA_W-1:0] proc_data_out,
	output logic      [IDX_W-1:0]  ram_addr_out,
	output logic                   ram_we_out,
	output logic      [DATA_W-1:0] ram_wdata_out,
	output logic                   busy_out
);
	sbf_dev_e          st_r, st_nxt;
	logic [1:0]        lk_r, lk_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic              burst_r, burst_nxt, itm_r, itm_nxt, inh_r, inh_nxt;
	logic              br_r, br_nxt, abb_r, abb_nxt, ts_r, ts_nxt, aoe_r, aoe_nxt;
	logic              dbb_r, dbb_nxt, pend_r, pend_nxt, done_r, done_nxt;
	logic              hold_r, hold_nxt, hv_r, hv_nxt, skip_r, skip_nxt;
	logic              pta_r, pta_nxt, we_r, we_nxt, busy_r, busy_nxt;
	logic [DATA_W-1:0] pd_r, pd_nxt, wd_r, wd_nxt, hd_r, hd_nxt;
	logic [IDX_W-1:0]  ra_r, ra_nxt, pi_r, pi_nxt;
	logic              seq_start, seq_step, seq_last, cap;
	logic [IDX_W-1:0]  seq_idx;
	logic [DATA_W-1:0] cap_data;

	// ========================================
	// beat order generator
	sbf_beat_seq u_seq (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.start_in  (seq_start),
		.crit_in   (addr_r[DW_LSB +: IDX_W]),
		.line64_in (line64_in),
		.cwf_in    (cwf_in),
		.single_in (!burst_r),
		.step_in   (seq_step),
		.idx_out   (seq_idx),
		.last_out  (seq_last)
	);

	// ========================================
	// beat capture: full speed data trails acknowledge by one clock,
	// half speed data comes with it
	always_comb
	begin
		seq_start = (st_r == SBF_D_LOOKUP) && (lk_r == 2'(LOOKUP_CLKS - 1));
		seq_step  = 1'b0;
		if (st_r == SBF_D_HIT)
			seq_step = !done_r;
		else if (dbb_r && !done_r)
			seq_step = bus.sys_transfer_ack;
		cap      = half_speed_in ? seq_step && (st_r == SBF_D_DATA) : pend_r;
		cap_data = bus.sys_data;
	end

	// ========================================
	// control sequence
	always_comb
	begin
		st_nxt    = st_r;
		lk_nxt    = lk_r;
		addr_nxt  = addr_r;
		burst_nxt = burst_r;
		itm_nxt   = itm_r;
		inh_nxt   = inh_r;
		br_nxt    = br_r;
		abb_nxt   = abb_r;
		ts_nxt    = 1'b0;
		aoe_nxt   = aoe_r;
		dbb_nxt   = dbb_r;
		done_nxt  = done_r;
		pend_nxt  = !half_speed_in && seq_step && (st_r == SBF_D_DATA);
		hv_nxt    = (st_r == SBF_D_HIT) && !done_r;
		ra_nxt    = ra_r;
		pi_nxt    = seq_step ? seq_idx : pi_r;
		// the cache address follows the beat being written, not the bus count
		if ((st_r == SBF_D_HIT) && seq_step)
			ra_nxt = seq_idx;
		else if (cap)
			ra_nxt = half_speed_in ? seq_idx : pi_r;
		case (st_r)
			SBF_D_IDLE:
			begin
				if (proc_transfer_start_in)
				begin
					addr_nxt  = proc_addr_in;
					burst_nxt = proc_burst_flag_in && !proc_cache_inhibit_in;
					inh_nxt   = proc_cache_inhibit_in;
					itm_nxt   = (proc_kind_in == SBF_KIND_RWITM);
					lk_nxt    = 2'h0;
					done_nxt  = 1'b0;
					st_nxt    = SBF_D_LOOKUP;
				end
			end
			SBF_D_LOOKUP:
			begin
				lk_nxt = lk_r + 2'h1;
				if (seq_start)
				begin
					// any kind that misses goes to the bus; inhibited never hits
					if (l2_hit_in && !inh_r)
						st_nxt = SBF_D_HIT;
					else
					begin
						br_nxt = 1'b1;
						st_nxt = SBF_D_REQ;
					end
				end
			end
			SBF_D_HIT:
			begin
				if (seq_step && seq_last)
					done_nxt = 1'b1;
				if (done_r && !hv_r)
					st_nxt = SBF_D_IDLE;
			end
			SBF_D_REQ:
			begin
				if (bus.sys_bus_grant && !bus.sys_address_busy)
				begin
					br_nxt  = 1'b0;
					abb_nxt = 1'b1;
					ts_nxt  = 1'b1;
					aoe_nxt = 1'b1;
					st_nxt  = SBF_D_ADDR;
				end
			end
			SBF_D_ADDR, SBF_D_DATA:
			begin
				if (bus.sys_address_ack && !ts_r)
				begin
					abb_nxt = 1'b0;
					aoe_nxt = 1'b0;
					st_nxt  = SBF_D_DATA;
				end
				if (!dbb_r && !done_r && bus.sys_data_grant && !bus.sys_data_busy && !ts_r)
					dbb_nxt = 1'b1;
				if (seq_step && seq_last)
				begin
					done_nxt = 1'b1;
					dbb_nxt  = 1'b0;
				end
				if (done_r && !pend_r && !hold_r && !aoe_r)
					st_nxt = SBF_D_IDLE;
			end
			default:
				st_nxt = SBF_D_IDLE;
		endcase
		busy_nxt  = (st_nxt != SBF_D_IDLE);
	end

	// ========================================
	// cache write and processor streaming; in half speed a beat that
	// lands right behind an acknowledge is held one clock
	always_comb
	begin
		we_nxt   = cap && !inh_r;
		wd_nxt   = cap ? cap_data : wd_r;
		hold_nxt = 1'b0;
		hd_nxt   = hd_r;
		pta_nxt  = 1'b0;
		pd_nxt   = pd_r;
		if (hv_r)
		begin
			pta_nxt = 1'b1;
			pd_nxt  = ram_rdata_in;
		end
		else if (hold_r)
		begin
			pta_nxt = 1'b1;
			pd_nxt  = hd_r;
		end
		else if (we_r || skip_r)
		begin
			if (half_speed_in && pta_r)
			begin
				hold_nxt = 1'b1;
				hd_nxt   = wd_r;
			end
			else
			begin
				pta_nxt = 1'b1;
				pd_nxt  = wd_r;
			end
		end
	end

	// inhibited beats skip the cache write but still reach the processor
	assign skip_nxt = cap && inh_r;

	// ========================================
	// registers
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r    <= SBF_D_IDLE;
			lk_r    <= 2'h0;
			addr_r  <= '0;
			{ra_r, pi_r} <= '0;
			{pd_r, wd_r, hd_r} <= '0;
			{burst_r, itm_r, inh_r, br_r, abb_r, ts_r, aoe_r, dbb_r} <= '0;
			{done_r, pend_r, hold_r, hv_r, skip_r, pta_r, we_r, busy_r} <= '0;
		end
		else
		begin
			st_r    <= st_nxt;
			lk_r    <= lk_nxt;
			addr_r  <= addr_nxt;
			{ra_r, pi_r} <= {ra_nxt, pi_nxt};
			{pd_r, wd_r, hd_r} <= {pd_nxt, wd_nxt, hd_nxt};
			{burst_r, itm_r, inh_r, br_r, abb_r, ts_r, aoe_r, dbb_r}
				<= {burst_nxt, itm_nxt, inh_nxt, br_nxt, abb_nxt, ts_nxt, aoe_nxt, dbb_nxt};
			{done_r, pend_r, hold_r, hv_r, skip_r, pta_r, we_r, busy_r}
				<= {done_nxt, pend_nxt, hold_nxt, hv_nxt, skip_nxt, pta_nxt, we_nxt, busy_nxt};
		end
	end

	// ========================================
	// outputs; attributes are gated by the address enable
	assign bus.sys_bus_request     = br_r;
	assign bus.sys_address_busy    = abb_r;
	assign bus.sys_transfer_start  = ts_r;
	assign bus.sys_addr_oe         = aoe_r;
	assign bus.sys_addr            = aoe_r ? addr_r : '0;
	assign bus.sys_burst_flag      = aoe_r && burst_r;
	assign bus.sys_memory_coherent = aoe_r && burst_r;
	assign bus.sys_invalidate_hint = aoe_r && burst_r && itm_r;
	assign bus.sys_data_busy       = dbb_r;
	assign proc_transfer_ack_out   = pta_r;
	assign proc_data_out           = pd_r;
	assign ram_addr_out            = ra_r;
	assign ram_we_out              = we_r;
	assign ram_wdata_out           = wd_r;
	assign busy_out                = busy_r;
endmodule : sbf_dev_end
`default_nettype wire

// ===== sbf_sys_end.sv
// arbiter and memory end of the system bus
`default_nettype none
module sbf_sys_end
	import sbf_pkg::*;
#(
	parameter int DEPTH = 64
)
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	sbf_bus_if.sys_mp              bus,
	input  wire logic              half_speed_in,
	input  wire logic              line64_in,
	input  wire logic              cwf_in,
	input  wire logic [WAIT_W-1:0] wait_in,
	input  wire logic              mem_we_in,
	input  wire logic [ADDR_W-1:0] mem_addr_in,
	input  wire logic [DATA_W-1:0] mem_wdata_in,
	output logic                   busy_out
);
	localparam int AW = $clog2(DEPTH);
	// the word address needs at least one bit above the beat index
	if (DEPTH <= BEATS_64B || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("DEPTH must be a power of two above one line");
	end

	logic [DATA_W-1:0] mem [DEPTH];
	sbf_host_e         st_r, st_nxt;
	logic [ADDR_W-1:0] a_r, a_nxt;
	logic [WAIT_W-1:0] w_r, w_nxt;
	logic              bg_r, bg_nxt, aack_r, aack_nxt, dbg_r, dbg_nxt, ta_r, ta_nxt;
	logic              ph_r, ph_nxt, burst_r, burst_nxt;
	logic [DATA_W-1:0] d_r, d_nxt;
	logic [IDX_W-1:0]  di_r, di_nxt, idx, lmask, sel;
	logic              last, start, step, busy_r, busy_nxt;
	logic [AW-1:0]     rd_a;

	sbf_beat_seq u_seq (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.start_in  (start),
		.crit_in   (bus.sys_addr[DW_LSB +: IDX_W]),
		.line64_in (line64_in),
		.cwf_in    (cwf_in),
		.single_in (!bus.sys_burst_flag),
		.step_in   (step),
		.idx_out   (idx),
		.last_out  (last)
	);

	// ========================================
	// arbiter, address acknowledge and memory beats
	always_comb
	begin
		start     = (st_r == SBF_H_IDLE) && bus.sys_transfer_start && bus.sys_addr_oe;
		st_nxt    = st_r;
		a_nxt     = start ? bus.sys_addr : a_r;
		burst_nxt = start ? bus.sys_burst_flag : burst_r;
		w_nxt     = w_r;
		bg_nxt    = bus.sys_bus_request;
		aack_nxt  = bus.sys_transfer_start;
		dbg_nxt   = (dbg_r || bus.sys_transfer_start) && !bus.sys_data_busy;
		ta_nxt    = 1'b0;
		ph_nxt    = 1'b0;
		step      = 1'b0;
		di_nxt    = di_r;
		case (st_r)
			SBF_H_IDLE:
			begin
				if (start)
				begin
					w_nxt  = wait_in;
					st_nxt = SBF_H_WAIT;
				end
			end
			SBF_H_WAIT:
			begin
				if (bus.sys_data_busy)
				begin
					if (w_r == '0)
						st_nxt = SBF_H_BEAT;
					else
						w_nxt = w_r - 4'h1;
				end
			end
			SBF_H_BEAT:
			begin
				// half speed beats only on every other clock
				ph_nxt = !ph_r;
				if (!half_speed_in || !ph_r)
				begin
					ta_nxt = 1'b1;
					step   = 1'b1;
					di_nxt = idx;
					if (last)
						st_nxt = SBF_H_TAIL;
				end
			end
			SBF_H_TAIL:
				st_nxt = SBF_H_IDLE;
			default:
				st_nxt = SBF_H_IDLE;
		endcase
		busy_nxt = (st_nxt != SBF_H_IDLE);
		// word bits outside the beat mask come from the address itself
		lmask = burst_r ? (line64_in ? IDX_W'(BEATS_64B - 1) : IDX_W'(BEATS_32B - 1)) : '0;
		sel   = half_speed_in ? idx : di_r;
		rd_a  = {a_r[AW+DW_LSB-1:DW_LSB+IDX_W], (sel & lmask) | (a_r[DW_LSB +: IDX_W] & ~lmask)};
		d_nxt = d_r;
		if (half_speed_in ? ta_nxt : ta_r)
			d_nxt = mem[rd_a];
	end

	always_ff @(posedge clk_in)
	begin
		if (mem_we_in)
			mem[mem_addr_in[AW+DW_LSB-1:DW_LSB]] <= mem_wdata_in;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r    <= SBF_H_IDLE;
			a_r     <= '0;
			burst_r <= 1'b0;
			w_r     <= '0;
			bg_r    <= 1'b0;
			aack_r  <= 1'b0;
			dbg_r   <= 1'b0;
			ta_r    <= 1'b0;
			ph_r    <= 1'b0;
			di_r    <= '0;
			d_r     <= '0;
			busy_r  <= 1'b0;
		end
		else
		begin
			st_r    <= st_nxt;
			a_r     <= a_nxt;
			burst_r <= burst_nxt;
			w_r     <= w_nxt;
			bg_r    <= bg_nxt;
			aack_r  <= aack_nxt;
			dbg_r   <= dbg_nxt;
			ta_r    <= ta_nxt;
			ph_r    <= ph_nxt;
			di_r    <= di_nxt;
			d_r     <= d_nxt;
			busy_r  <= busy_nxt;
		end
	end

	assign bus.sys_bus_grant    = bg_r;
	assign bus.sys_address_ack  = aack_r;
	assign bus.sys_data_grant   = dbg_r;
	assign bus.sys_transfer_ack = ta_r;
	assign bus.sys_data         = d_r;
	assign busy_out             = busy_r;
endmodule : sbf_sys_end
`default_nettype wire

// ===== sbf_bus_props.sv
// concurrent checks on the system bus joining the two ends
`default_nettype none
module sbf_bus_props
	import sbf_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              rst_in,
	input wire logic              half_speed_in,
	input wire logic              line64_in,
	input wire logic              sys_bus_request,
	input wire logic              sys_address_busy,
	input wire logic              sys_transfer_start,
	input wire logic              sys_burst_flag,
	input wire logic              sys_memory_coherent,
	input wire logic              sys_invalidate_hint,
	input wire logic [ADDR_W-1:0] sys_addr,
	input wire logic              sys_addr_oe,
	input wire logic              sys_address_ack,
	input wire logic              sys_data_grant,
	input wire logic              sys_data_busy,
	input wire logic              sys_transfer_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// ====================
	// beat tally
	logic [3:0] beats_r, beats_nxt;
	logic       burst_r, burst_nxt;
	// restarted at each start so a stale count never leaks across tenures
	always_comb
	begin
		beats_nxt = sys_transfer_start ? 4'h0 : beats_r + {3'h0, sys_transfer_ack};
		burst_nxt = sys_transfer_start ? sys_burst_flag : burst_r;
	end
	// register the tally
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			beats_r <= 4'h0;
			burst_r <= 1'b0;
		end
		else
		begin
			beats_r <= beats_nxt;
			burst_r <= burst_nxt;
		end
	end
	// ====================
	// address tenure
	grant_take_a: assert property ($rose(sys_transfer_start) |->
		sys_address_busy && sys_addr_oe && !sys_bus_request) else $error("bad start");
	start_pulse_a: assert property (sys_transfer_start |=> !sys_transfer_start)
		else $error("start too long");
	aack_follows_a: assert property (sys_transfer_start |=> sys_address_ack)
		else $error("no address ack");
	tenure_release_a: assert property (sys_address_ack |=>
		!sys_addr_oe && !sys_address_busy) else $error("address not released");
	attr_hold_a: assert property (sys_address_busy && $past(sys_address_busy) |->
		$stable(sys_addr) && $stable(sys_burst_flag)) else $error("attribute moved");
	burst_coherent_a: assert property (sys_transfer_start && sys_burst_flag |->
		sys_memory_coherent) else $error("burst not coherent");
	single_no_inv_a: assert property (sys_transfer_start && !sys_burst_flag |->
		!sys_invalidate_hint) else $error("single with invalidate");
	// ====================
	// data tenure
	dgrant_qual_a: assert property ($rose(sys_data_busy) |-> $past(sys_data_grant))
		else $error("data busy without grant");
	ack_in_tenure_a: assert property (sys_transfer_ack |-> sys_data_busy)
		else $error("ack outside tenure");
	half_gap_a: assert property (half_speed_in && sys_transfer_ack |=> !sys_transfer_ack)
		else $error("half speed acks adjacent");
	beat_count_a: assert property ($fell(sys_data_busy) |-> beats_r ==
		(burst_r ? (line64_in ? 4'h8 : 4'h4) : 4'h1)) else $error("wrong beat count");
endmodule : sbf_bus_props
`default_nettype wire

// ===== tb_top.sv
// self-checking bench: both ends of the line fill joined on one bus
`default_nettype none
module tb_top
	import sbf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
	// ====================
	// signals
	logic              clk_in = 1'b0;
	logic              rst_in = 1'b1;
	logic              half, l64, cwf, pts, pbst, pci, hit, mwe;
	sbf_kind_e         kind;
	logic [ADDR_W-1:0] pa, ma, sa_s;
	logic [DATA_W-1:0] rrd, mwd, pdo, rwd;
	logic [WAIT_W-1:0] wt;
	logic              pta, rwe, dbusy, sbusy, inv_s, bst_s;
	logic [IDX_W-1:0]  ra;
	logic [DATA_W-1:0] mem [64];
	logic [DATA_W-1:0] l2 [8];
	logic [DATA_W-1:0] ex2 [8];
	int                mismatches, n_tests, seed, ts_n, wr_n;
	sbf_bus_if bus_if ();
	sbf_dev_end sbf_dev_end_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus_if.dev_mp),
		.half_speed_in(half), .line64_in(l64), .cwf_in(cwf), .proc_transfer_start_in(pts),
		.proc_addr_in(pa), .proc_burst_flag_in(pbst), .proc_cache_inhibit_in(pci),
		.proc_kind_in(kind), .l2_hit_in(hit), .ram_rdata_in(rrd),
		.proc_transfer_ack_out(pta), .proc_data_out(pdo), .ram_addr_out(ra),
		.ram_we_out(rwe), .ram_wdata_out(rwd), .busy_out(dbusy));
	sbf_sys_end sbf_sys_end_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(bus_if.sys_mp),
		.half_speed_in(half), .line64_in(l64), .cwf_in(cwf), .wait_in(wt), .mem_we_in(mwe),
		.mem_addr_in(ma), .mem_wdata_in(mwd), .busy_out(sbusy));
	sbf_bus_props sbf_bus_props_inst (.clk_in(clk_in), .rst_in(rst_in), .half_speed_in(half),
		.line64_in(l64), .sys_bus_request(bus_if.sys_bus_request),
		.sys_address_busy(bus_if.sys_address_busy),
		.sys_transfer_start(bus_if.sys_transfer_start),
		.sys_burst_flag(bus_if.sys_burst_flag),
		.sys_memory_coherent(bus_if.sys_memory_coherent),
		.sys_invalidate_hint(bus_if.sys_invalidate_hint), .sys_addr(bus_if.sys_addr),
		.sys_addr_oe(bus_if.sys_addr_oe), .sys_address_ack(bus_if.sys_address_ack),
		.sys_data_grant(bus_if.sys_data_grant), .sys_data_busy(bus_if.sys_data_busy),
		.sys_transfer_ack(bus_if.sys_transfer_ack));
	// ====================
	// clock, cache array stand-in and bus monitor
	always #20 clk_in = ~clk_in;
	// one line of cache, read through; the device end registers what it reads
	assign rrd = l2[ra];
	always @(posedge clk_in)
	begin
		if (rwe === 1'b1)
		begin
			l2[ra] <= rwd;
			wr_n <= wr_n + 1;
		end
		if (bus_if.sys_transfer_start === 1'b1)
		begin
			ts_n <= ts_n + 1;
			inv_s <= bus_if.sys_invalidate_hint;
			bst_s <= bus_if.sys_burst_flag;
			sa_s <= bus_if.sys_addr;
		end
	end
	// ====================
	// verdict
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// one processor access, checked beat by beat
	task automatic run(input logic h, input logic b, input logic c, input sbf_kind_e k,
		input logic [ADDR_W-1:0] a);
		int n, w, j, cyc, t, ts0, wr0;
		logic prev;
		logic [DATA_W-1:0] e;
		n = (c || !b) ? 1 : (l64 ? 8 : 4);
		w = a[8:3];
		ts0 = ts_n;
		wr0 = wr_n;
		prev = 1'b0;
		j = 0;
		hit = h;
		pbst = b;
		pci = c;
		kind = k;
		pa = a;
		pts = 1'b1;
		@(negedge clk_in);
		pts = 1'b0;
		@(negedge clk_in);
		`CHK(bus_if.sys_bus_request, 1'b0)
		@(negedge clk_in);
		`CHK(bus_if.sys_bus_request, !h)
		cyc = 2;
		for (t = 0; t < 400 && (j < n || dbusy !== 1'b0 || sbusy !== 1'b0); t++)
		begin
			@(negedge clk_in);
			cyc++;
			if (pta === 1'b1)
			begin
				e = mem[(w & ~(n - 1)) | (((cwf ? w : 0) + j) & (n - 1))];
				if (h)
					e = ex2[((cwf ? w : 0) + j) & (n - 1)];
				`CHK(pdo, e)
				`CHK(prev & half & !h, 1'b0)
				if (h && j == 0)
					`CHK(cyc, 4)
				j++;
			end
			prev = (pta === 1'b1);
		end
		if (t == 400)
		begin
			mismatches++;
			tally_and_finish();
		end
		`CHK(j, n)
		`CHK(ts_n - ts0, h ? 0 : 1)
		`CHK(wr_n - wr0, (h || c) ? 0 : n)
		if (!h)
		begin
			`CHK(bst_s, n > 1)
			`CHK(inv_s, k == SBF_KIND_RWITM && n > 1)
			`CHK(sa_s, a)
		end
		if (!h && n > 1)
			for (int q = 0; q < n; q++)
				ex2[q] = mem[(w & ~(n - 1)) | q];
		$display("test hit %0d kind %0d beats %0d done", h, k, n);
	endtask : run
	// ====================
	// main sequence: preload, then every mode and kind per configuration
	initial
	begin
		logic [ADDR_W-1:0] a;
		seed = 8086;
		mismatches = 0;
		n_tests = 0;
		{half, l64, cwf, pts, pbst, pci, hit, mwe} = 8'h00;
		kind = SBF_KIND_READ;
		pa = '0;
		ma = '0;
		mwd = '0;
		wt = '0;
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		for (int q = 0; q < 64; q++)
		begin
			mwd = {$random(seed), $random(seed)};
			mem[q] = mwd;
			ma = ADDR_W'(q << 3);
			mwe = 1'b1;
			@(negedge clk_in);
		end
		mwe = 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			{cwf, l64, half} = c[2:0];
			// no wait and longest wait as corners, random between
			wt = (c == 0) ? 4'h0 : (c == 7) ? 4'hf : WAIT_W'($random(seed));
			a = ADDR_W'($random(seed) & 32'h1f8);
			run(1'b0, 1'b1, 1'b0, SBF_KIND_READ, a);
			run(1'b1, 1'b1, 1'b0, SBF_KIND_READ, a);
			run(1'b0, 1'b1, 1'b0, SBF_KIND_RWITM, a ^ 32'h40);
			run(1'b0, 1'b1, 1'b1, SBF_KIND_OTHER, a ^ 32'h80);
			run(1'b0, 1'b0, 1'b0, SBF_KIND_OTHER, a ^ 32'h100);
		end
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
